/* File: timer_a_defs.svh */
// Register map, field positions, reset values and divider widths of timer A
`ifndef TIMER_A_DEFS_SVH
`define TIMER_A_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define TA_CONTROL_ADDR 8'h18
`define TA_PERIOD_ADDR 8'h1C
`define TA_STATUS_ADDR 8'h20
`define TB_CONTROL_ADDR 8'h24
`define TA_WIDTH_ADDR 8'h2C
`define TA_AUX_ADDR 8'h30

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_PRESET_BIT 7
`define CTL_CLK_HI 6
`define CTL_CLK_LO 4
`define CTL_RUN_BIT 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
`define AUX_TAP_BIT 0
`define AUX_LOW_SPEED_BIT 1

// ----------------------------------------------------------------------------
// Reset values and prescaler
// ----------------------------------------------------------------------------
`define CONTROL_RST 8'h00
`define COMPARE_RST 8'hFF
`define AUX_RST 8'h00
`define DIV_W 11
`define LF_DIV_W 3

`endif

/* File: timer_a_pkg.sv */
// Types shared by the timer A modules
`default_nettype none
package timer_a_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0] {
        CK_HF_2E11 = 3'h0,
        CK_HF_2E7 = 3'h1,
        CK_HF_2E5 = 3'h2,
        CK_HF_2E3 = 3'h3,
        CK_LF = 3'h4,
        CK_HF_2 = 3'h5,
        CK_HF = 3'h6,
        CK_PIN = 3'h7
    } clk_sel_t;
    typedef enum logic [2:0] {
        MD_TIMER = 3'h0,
        MD_DIVIDER = 3'h1,
        MD_PWM = 3'h2,
        MD_CASCADE = 3'h3
    } mode_t;
    typedef enum logic [2:0] {
        BM_TIMER16 = 3'h4,
        BM_WARMUP = 3'h5,
        BM_PWM16 = 3'h6,
        BM_PPG16 = 3'h7
    } b_mode_t;
endpackage
`default_nettype wire

/* File: tick_if.sv */
// Count clock request and tick between the timer core and its selector
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
    logic [2:0] sel;
    logic tap_option;
    logic low_speed;
    logic warmup_ok;
    logic lf_tick;
    logic pin_tick;
    logic tick;
    modport core_side (output sel, tap_option, low_speed, warmup_ok, lf_tick, pin_tick,
        input tick);
    modport sel_side (input sel, tap_option, low_speed, warmup_ok, lf_tick, pin_tick,
        output tick);
endinterface
`default_nettype wire

/* File: clock_tick_select.sv */
// Prescaler and count clock source selection
`timescale 1ns/1ns
`default_nettype none
`include "timer_a_defs.svh"
module clock_tick_select
    import timer_a_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Core
    tick_if.sel_side t
);
    logic [`DIV_W-1:0] div;
    logic [`LF_DIV_W-1:0] lf_div;
    logic lf_div8;

    // ------------------------------------------------------------------------
    // Free-running dividers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div <= '0;
        else if (ce_i)
            div <= div + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lf_div <= '0;
        else if (ce_i && t.lf_tick)
            lf_div <= lf_div + 1'b1;
    end

    assign lf_div8 = t.lf_tick && (&lf_div);

    // ------------------------------------------------------------------------
    // Source select
    // ------------------------------------------------------------------------
    // Low-speed operation offers only the low clock taps, the pin and warm-up
    always_comb
    begin
        t.tick = 1'b0;
        if (t.low_speed)
        begin
            case (clk_sel_t'(t.sel))
                CK_HF_2E11: t.tick = lf_div8;
                CK_LF: t.tick = t.lf_tick;
                CK_HF: t.tick = t.warmup_ok;
                CK_PIN: t.tick = t.pin_tick;
                default: t.tick = 1'b0;
            endcase
        end
        else
        begin
            case (clk_sel_t'(t.sel))
                CK_HF_2E11: t.tick = t.tap_option ? lf_div8 : (&div[10:0]);
                CK_HF_2E7: t.tick = &div[6:0];
                CK_HF_2E5: t.tick = &div[4:0];
                CK_HF_2E3: t.tick = &div[2:0];
                CK_LF: t.tick = t.lf_tick;
                CK_HF_2: t.tick = div[0];
                CK_HF: t.tick = 1'b1;
                CK_PIN: t.tick = t.pin_tick;
                default: t.tick = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: eight_bit_timer_control.sv */
// Timer A: control registers, counter, flip-flop and cascade upper byte
//
// Functional notes
// - One control register and two 8-bit compare registers, period and width.
// - Period at 0x1C, width at 0x2C, read/write, reset to all ones.
// - Control at 0x18, reset zero: preset bit7, clock 6:4, run bit3, mode 2:0.
// - Clock select codes map to high-freq taps, low-freq, or the pin.
// - Low-speed operation offers only codes 000, 100, 111, and 110 for warm-up.
// - Run bit low stops and clears the counter; high runs it.
// - Mode: timer, divider, PWM, cascade; codes 1xx are reserved.
// - Cascade: clock from timer A, run and preset from timer B.
// - Timer B mode 1xx: upper byte counts on lower overflow only.
// - Timer B modes: 100 counter, 101 warm-up, 110 PWM, 111 PPG; here 110 and 111 only count like 100.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "timer_a_defs.svh"
module eight_bit_timer_control
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic [7:0] adr_i,
    input wire timer_a_pkg::word_t dat_i,
    output timer_a_pkg::word_t dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // Pins
    input wire logic low_freq_clock_i,
    input wire logic timer_pin_i,
    // Timer outputs
    output logic timer_flipflop_o,
    output logic match_o,
    output timer_a_pkg::byte_t upper_count_o
);
    import timer_a_pkg::*;

    byte_t timer_a_control;
    byte_t timer_a_period_compare;
    byte_t timer_a_width_compare;
    byte_t timer_b_control;
    byte_t aux_control;
    byte_t count;
    byte_t next_count;
    byte_t rd_byte;
    logic [2:0] lf_sync;
    logic [2:0] pin_sync;
    logic req;
    logic wr;
    logic cascade;
    logic run;
    logic preset;
    logic hit;
    mode_t mode;
    logic [2:0] b_mode;
    tick_if t ();

    clock_tick_select u_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .t(t)
    );

    // ------------------------------------------------------------------------
    // Wishbone register access
    // ------------------------------------------------------------------------
    // One wait state: ack is registered and drops the cycle after it rises
    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0] && ce_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else if (ce_i)
            ack_o <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_a_control <= `CONTROL_RST;
            timer_a_period_compare <= `COMPARE_RST;
            timer_a_width_compare <= `COMPARE_RST;
            timer_b_control <= `CONTROL_RST;
            aux_control <= `AUX_RST;
        end
        else if (wr)
        begin
            // Writes while counting are the caller's duty to avoid
            case (adr_i)
                `TA_CONTROL_ADDR: timer_a_control <= dat_i[7:0];
                `TA_PERIOD_ADDR: timer_a_period_compare <= dat_i[7:0];
                `TA_WIDTH_ADDR: timer_a_width_compare <= dat_i[7:0];
                `TB_CONTROL_ADDR: timer_b_control <= dat_i[7:0];
                `TA_AUX_ADDR: aux_control <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        case (adr_i)
            `TA_CONTROL_ADDR: rd_byte = timer_a_control;
            `TA_PERIOD_ADDR: rd_byte = timer_a_period_compare;
            `TA_WIDTH_ADDR: rd_byte = timer_a_width_compare;
            `TA_STATUS_ADDR: rd_byte = count;
            `TB_CONTROL_ADDR: rd_byte = timer_b_control;
            `TA_AUX_ADDR: rd_byte = {6'h00, aux_control[1:0]};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h00000000;
        else if (ce_i && req)
            dat_o <= {24'h000000, rd_byte};
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lf_sync <= 3'h0;
            pin_sync <= 3'h7;
        end
        else if (ce_i)
        begin
            lf_sync <= {lf_sync[1:0], low_freq_clock_i};
            pin_sync <= {pin_sync[1:0], timer_pin_i};
        end
    end

    // ------------------------------------------------------------------------
    // Count source and effective control
    // ------------------------------------------------------------------------
    assign mode = mode_t'(timer_a_control[`CTL_MODE_HI:`CTL_MODE_LO]);
    assign b_mode = timer_b_control[`CTL_MODE_HI:`CTL_MODE_LO];
    assign cascade = (mode == MD_CASCADE);
    assign run = cascade ? timer_b_control[`CTL_RUN_BIT]
        : timer_a_control[`CTL_RUN_BIT];
    assign preset = cascade ? timer_b_control[`CTL_PRESET_BIT]
        : timer_a_control[`CTL_PRESET_BIT];

    assign t.sel = timer_a_control[`CTL_CLK_HI:`CTL_CLK_LO];
    assign t.tap_option = aux_control[`AUX_TAP_BIT];
    assign t.low_speed = aux_control[`AUX_LOW_SPEED_BIT];
    assign t.warmup_ok = cascade && (b_mode == BM_WARMUP);
    assign t.lf_tick = lf_sync[1] && !lf_sync[2];
    assign t.pin_tick = !pin_sync[1] && pin_sync[2];

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    assign next_count = count + 8'h01;
    // PWM runs the full byte; other live modes clear on period match
    assign hit = run && t.tick && (mode != MD_PWM) && !mode[2]
        && (next_count == timer_a_period_compare);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count <= 8'h00;
        else if (ce_i)
        begin
            if (!run)
                count <= 8'h00;
            else if (t.tick && !mode[2])
                count <= hit ? 8'h00 : next_count;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_o <= 1'b0;
        else if (ce_i)
            match_o <= hit;
    end

    // ------------------------------------------------------------------------
    // Timer flip-flop
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            timer_flipflop_o <= 1'b0;
        else if (ce_i)
        begin
            if (!run)
                timer_flipflop_o <= preset;
            else if (t.tick)
            begin
                case (mode)
                    MD_DIVIDER: if (hit) timer_flipflop_o <= !timer_flipflop_o;
                    MD_PWM:
                    begin
                        if (count == timer_a_width_compare)
                            timer_flipflop_o <= !preset;
                        else if (count == 8'hFF)
                            timer_flipflop_o <= preset;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Cascade upper byte
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            upper_count_o <= 8'h00;
        else if (ce_i)
        begin
            if (!run || !cascade || !b_mode[2])
                upper_count_o <= 8'h00;
            else if (hit)
                upper_count_o <= upper_count_o + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_running_tick;
        ce_i && run && t.tick;
    endsequence

    sequence s_lower_wrap;
        s_running_tick ##0 hit;
    endsequence

    a_reset_values: assert property ($past(rst_i) |-> timer_a_control == 8'h00
        && timer_a_period_compare == 8'hFF && timer_a_width_compare == 8'hFF)
        else $error("bad reset values");
    // A frozen clock enable legally holds ack, so only enabled cycles count
    a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack held more than one cycle");
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("ack missing after request");
    a_stop_clears_count: assert property (ce_i && !run |=> count == 8'h00)
        else $error("stopped counter not cleared");
    a_period_match_clears: assert property (s_lower_wrap |=> count == 8'h00 && match_o)
        else $error("period match did not clear");
    a_divider_toggles: assert property (s_lower_wrap ##0 (mode == MD_DIVIDER)
        |=> timer_flipflop_o != $past(timer_flipflop_o))
        else $error("divider flip-flop did not toggle");
    a_reserved_holds: assert property (ce_i && mode[2] |=> $stable(count))
        else $error("reserved mode counted");
    a_upper_on_wrap: assert property (s_lower_wrap ##0 (cascade && b_mode[2])
        |=> upper_count_o == $past(upper_count_o) + 8'h01)
        else $error("upper byte missed lower overflow");
    a_low_speed_limit: assert property (t.low_speed
        && (t.sel inside {3'h1, 3'h2, 3'h3, 3'h5}) |-> !t.tick)
        else $error("disallowed clock in low-speed");
    a_fast_clock_tick: assert property (!t.low_speed && t.sel == 3'h6 |-> t.tick)
        else $error("full-rate clock not ticking");
endmodule
`default_nettype wire

/* File: eight_bit_timer_control_tb.sv */
// Self-checking bench for the timer A register block
`timescale 1ns/1ns
`default_nettype none
module eight_bit_timer_control_tb;
    import timer_a_pkg::*;
    logic clk_i;
    logic rst_i;
    logic ce_i;
    logic [7:0] adr_i;
    word_t dat_i;
    word_t dat_o;
    logic [3:0] sel_i;
    logic we_i;
    logic cyc_i;
    logic stb_i;
    logic ack_o;
    logic low_freq_clock_i;
    logic timer_pin_i;
    logic timer_flipflop_o;
    logic match_o;
    byte_t upper_count_o;
    word_t expq[$];
    int failures = 0;
    int checks_done = 0;
    byte_t ctl;
    byte_t d;
    int a;
    int b;
    // Clock codes, low-speed/tap options and expected divide ratios
    logic [2:0] codes[10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h4, 3'h7, 3'h0, 3'h4};
    logic [1:0] auxs[10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    int divs[10] = '{2048, 128, 32, 8, 2, 1, 16, 16, 128, 16};

    eight_bit_timer_control dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .low_freq_clock_i(low_freq_clock_i), .timer_pin_i(timer_pin_i),
        .timer_flipflop_o(timer_flipflop_o), .match_o(match_o),
        .upper_count_o(upper_count_o)
    );

    // ------------------------------------------------------------------------
    // Clock, slow sources, watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Both slow sources give one counted edge every 16 cycles
    initial
    begin
        forever
        begin
            repeat (8) @(posedge clk_i);
            low_freq_clock_i <= ~low_freq_clock_i;
            timer_pin_i <= ~timer_pin_i;
        end
    end

    initial
    begin
        repeat (100000) @(posedge clk_i);
        failures++;
        conclude();
    end

    // ------------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------------
    task automatic check(input word_t seen, input word_t expv);
        checks_done++;
        if (seen !== expv)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    // Read answers are matched against the oldest noted expectation
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
            check(dat_o, expq.pop_front());
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------------
    task automatic wb(input logic [7:0] ad, input logic w, input byte_t dv, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= {24'h000000, dv};
        sel_i <= s;
        // No cycle budget here: only the watchdog ends a wait for ack
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input byte_t dv);
        wb(ad, 1'b1, dv, 4'h1);
    endtask

    task automatic rd(input logic [7:0] ad, input byte_t e);
        expq.push_back({24'h000000, e});
        wb(ad, 1'b0, 8'h00, 4'hF);
    endtask

    // Waits for a match pulse (0), an upper byte change (1) or a flip-flop change (2)
    task automatic wait_ev(input int kind, output int n);
        byte_t u;
        logic f;
        u = upper_count_o;
        f = timer_flipflop_o;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (n < 20000 && ((kind == 0) ? (match_o !== 1'b1)
            : (kind == 1) ? (upper_count_o === u) : (timer_flipflop_o === f)));
        if (n >= 20000)
        begin
            failures++;
            conclude();
        end
    endtask

    // Fields change only while stopped, so stop with the old fields first
    task automatic restart(input byte_t nctl, input logic [1:0] aux);
        wr(`TA_CONTROL_ADDR, ctl & 8'hF7);
        wr(`TA_AUX_ADDR, {6'h00, aux});
        d = byte_t'($urandom_range(5, 2));
        wr(`TA_PERIOD_ADDR, d);
        ctl = nctl;
        wr(`TA_CONTROL_ADDR, ctl);
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial
    begin
        {rst_i, ce_i, cyc_i, stb_i, we_i, low_freq_clock_i, timer_pin_i} = 7'b1100001;
        adr_i = 8'h00;
        dat_i = 32'h00000000;
        sel_i = 4'h0;
        ctl = 8'h00;
        void'($urandom(32'hd683));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TA_CONTROL_ADDR, `CONTROL_RST);
        rd(`TA_PERIOD_ADDR, `COMPARE_RST);
        rd(`TA_WIDTH_ADDR, `COMPARE_RST);
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            d = byte_t'($urandom);
            wr(`TA_WIDTH_ADDR, ~d);
            wr(`TA_PERIOD_ADDR, d);
            rd(`TA_PERIOD_ADDR, d);
            rd(`TA_WIDTH_ADDR, ~d);
        end
        // Lane 0 not selected, so the write must be dropped
        wb(`TA_PERIOD_ADDR, 1'b1, ~d, 4'hE);
        rd(`TA_PERIOD_ADDR, d);
        wr(8'h40, 8'h33);
        rd(8'h40, 8'h00);
        ctl = byte_t'($urandom) & 8'hF7;
        wr(`TA_CONTROL_ADDR, ctl);
        rd(`TA_CONTROL_ADDR, ctl);
        $display("test register access done");
        foreach (ctl[i])
        begin
            ctl = 8'h80 >> i;
            ctl[3] = 1'b0;
            wr(`TA_CONTROL_ADDR, ctl);
            repeat (2) @(posedge clk_i);
            check({31'h0, timer_flipflop_o}, {31'h0, ctl[7]});
        end
        $display("test preset done");
        for (int i = 0; i < 10; i++)
        begin
            restart({1'b0, codes[i], 4'h8}, auxs[i]);
            wait_ev(1'b0, a);
            wait_ev(1'b0, b);
            check(word_t'(b), word_t'(divs[i] * int'(d)));
        end
        $display("test clock select done");
        // Low speed: a high-speed tap must not count
        restart(8'h58, 2'h2);
        repeat (60) @(posedge clk_i);
        rd(`TA_STATUS_ADDR, 8'h00);
        restart(8'h6C, 2'h0);
        repeat (20) @(posedge clk_i);
        rd(`TA_STATUS_ADDR, 8'h00);
        // Slow source: one tick lands 16 cycles after a match, then stopping clears it
        restart(8'h48, 2'h0);
        wait_ev(0, a);
        repeat (20) @(posedge clk_i);
        rd(`TA_STATUS_ADDR, 8'h01);
        wr(`TA_CONTROL_ADDR, ctl & 8'hF7);
        rd(`TA_STATUS_ADDR, 8'h00);
        $display("test low speed and reserved done");
        // Divider toggles on each match; a low clock enable freezes it all
        restart(8'h69, 2'h0);
        wait_ev(0, a);
        check({31'h0, timer_flipflop_o}, 32'h1);
        ce_i <= 1'b0;
        repeat (11) @(posedge clk_i);
        ce_i <= 1'b1;
        check({31'h0, timer_flipflop_o}, 32'h1);
        wait_ev(0, b);
        check({31'h0, timer_flipflop_o}, 32'h0);
        check(word_t'(b), word_t'(d));
        // PWM high from width match to wrap; width rewritten while running
        restart(8'h62, 2'h0);
        for (int i = 0; i < 2; i++)
        begin
            a = $urandom_range(200, 16);
            wr(`TA_WIDTH_ADDR, byte_t'(a));
            if (i == 0)
            begin
                ctl = 8'h6A;
                wr(`TA_CONTROL_ADDR, ctl);
            end
            do
            begin
                wait_ev(2, b);
            end
            while (timer_flipflop_o !== 1'b1);
            wait_ev(2, b);
            check(word_t'(b), word_t'(255 - a));
        end
        $display("test divider and PWM done");
        // Cascade, then low-speed warm-up: run from timer B, clock from timer A
        for (int i = 0; i < 2; i++)
        begin
            restart(8'h63, {i[0], 1'b0});
            wr(`TB_CONTROL_ADDR, {7'h06, i[0]});
            wait_ev(1, a);
            wait_ev(1, b);
            check(word_t'(b), word_t'(d));
            wr(`TB_CONTROL_ADDR, {7'h02, i[0]});
        end
        $display("test cascade done");
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule
`default_nettype wire
